// [hdl/rsf_linreg.sv]
// Purpose: control of one linear regulator (set point, modes, protection)
// Assumes: short detect input synchronous to i_clk_sys
// Notes:   protection clear of enable wins over a software write
`timescale 1ns/1ps
module rsf_linreg
	import rsf_pkg::*;
#(
	parameter logic [DB_W-1:0] DEBOUNCE_CYC = DEBOUNCE_CYC_DEF
) (
	input  wire logic   i_clk_sys,
	input  wire logic   i_rst,
	rsf_lr_if.reg_side  lr
);

	typedef struct packed {
		logic [CFG_W-1:0] cfg;
		logic [DB_W-1:0]  cnt;
		logic             active;
		logic             evt;
		logic             on;
		logic             lp;
		logic             dis;
		logic             full;
		logic [MV_W-1:0]  mv;
	} rsf_lr_state_t;

	localparam rsf_lr_state_t LR_RST = '{
		cfg: CFG_RST, cnt: '0, active: 1'b0, evt: 1'b0, on: 1'b0,
		lp: 1'b0, dis: 1'b1, full: 1'b0, mv: LR_LO_BASE
	};

	rsf_lr_state_t s_reg;
	rsf_lr_state_t s_next;
	logic          on_v;
	logic          lp_v;

	// =========================================================
	// next state
	always_comb begin
		s_next     = s_reg;
		s_next.evt = 1'b0;
		on_v       = 1'b0;
		lp_v       = 1'b0;
		if (!lr.sc_raw) begin
			s_next.cnt    = '0;
			s_next.active = 1'b0;
		end else if (!s_reg.active) begin
			if (s_reg.cnt == DEBOUNCE_CYC - 1'b1) begin
				s_next.evt    = 1'b1;
				s_next.active = 1'b1;
				s_next.cnt    = '0;
			end else begin
				s_next.cnt = s_reg.cnt + 1'b1;
			end
		end
		if (lr.wr) begin
			s_next.cfg = lr.wdata & CFG_WMASK;
		end
		if (s_reg.evt && lr.spe) begin
			s_next.cfg[CFG_EN] = 1'b0;
		end
		unique case (lr.mode)
			MODE_OFF:     on_v = 1'b0;
			MODE_RUN:     on_v = s_reg.cfg[CFG_EN];
			MODE_STANDBY: begin
				on_v = s_reg.cfg[CFG_EN] & s_reg.cfg[CFG_STBY];
				lp_v = s_reg.cfg[CFG_LP];
			end
			MODE_SLEEP:   begin
				on_v = s_reg.cfg[CFG_EN] & s_reg.cfg[CFG_SLEEP];
				lp_v = s_reg.cfg[CFG_LP];
			end
		endcase
		s_next.on   = on_v;
		s_next.lp   = on_v & lp_v;
		s_next.dis  = ~on_v;
		s_next.full = on_v & lr.otp_switch;
		s_next.mv   = lr_code_mv(s_reg.cfg[CFG_SP_W-1:0]);
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			s_reg <= LR_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign lr.cfg       = s_reg.cfg;
	assign lr.evt       = s_reg.evt;
	assign lr.active    = s_reg.active;
	assign lr.on        = s_reg.on;
	assign lr.low_power = s_reg.lp;
	assign lr.discharge = s_reg.dis;
	assign lr.full_on   = s_reg.full;
	assign lr.mv        = s_reg.mv;

	// =========================================================
	// checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	discharge_off_a: assert property (
		!s_reg.cfg[CFG_EN] |=> lr.discharge
	) else $error("discharge not asserted while disabled");

	protect_clear_a: assert property (
		lr.evt && lr.spe |=> !s_reg.cfg[CFG_EN]
	) else $error("enable not cleared by protection");

	no_auto_off_a: assert property (
		lr.evt && !lr.spe && s_reg.cfg[CFG_EN] && !lr.wr
		|=> s_reg.cfg[CFG_EN]
	) else $error("enable cleared with protection off");

	debounce_len_a: assert property (
		lr.evt |-> $past(lr.sc_raw) && $past(s_reg.cnt) == DEBOUNCE_CYC - 1'b1
	) else $error("fault flagged before debounce expired");

	switch_full_a: assert property (
		lr.on && $past(lr.otp_switch) |-> lr.full_on
	) else $error("load switch not fully on");

	run_on_a: assert property (
		lr.mode == MODE_RUN && s_reg.cfg[CFG_EN]
		&& $stable(lr.mode) [*2] |-> lr.on
	) else $error("regulator off in run while enabled");

	sp_encode_a: assert property (
		!lr.wr && !s_reg.cfg[4] |=> s_reg.mv ==
		LR_LO_BASE + LR_LO_STEP * {8'h00, $past(s_reg.cfg[3:0])}
	) else $error("low range set point encoding wrong");

endmodule

// [hdl/rsf_lr_if.sv]
// Purpose: link between register block and one linear regulator control
// Assumes: single clock domain
// Notes:   ctl_side drives commands, reg_side returns state
`timescale 1ns/1ps
interface rsf_lr_if;
	import rsf_pkg::*;
	logic             wr;
	logic [CFG_W-1:0] wdata;
	rsf_mode_t        mode;
	logic             spe;
	logic             sc_raw;
	logic             otp_switch;
	logic [CFG_W-1:0] cfg;
	logic             evt;
	logic             active;
	logic             on;
	logic             low_power;
	logic             discharge;
	logic             full_on;
	logic [MV_W-1:0]  mv;

	modport ctl_side (
		output wr, wdata, mode, spe, sc_raw, otp_switch,
		input  cfg, evt, active, on, low_power, discharge, full_on, mv
	);
	modport reg_side (
		input  wr, wdata, mode, spe, sc_raw, otp_switch,
		output cfg, evt, active, on, low_power, discharge, full_on, mv
	);
endinterface

// [hdl/rsf_pkg.sv]
// Purpose: shared constants, types and encoders for regulator control
// Assumes: APB register map, 32-bit data, one system clock
// Notes:   set-point encoders return millivolts
package rsf_pkg;

	// =========================================================
	// modes
	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_RUN,
		MODE_STANDBY,
		MODE_SLEEP
	} rsf_mode_t;

	// =========================================================
	// register map
	localparam int unsigned ADDR_W       = 8;
	localparam int unsigned DATA_W       = 32;
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_BUCK3    = 8'h04;
	localparam logic [7:0]  OFS_LR1      = 8'h08;
	localparam logic [7:0]  OFS_LR3      = 8'h0C;
	localparam logic [7:0]  OFS_INT_STAT = 8'h10;
	localparam logic [7:0]  OFS_INT_MASK = 8'h14;
	localparam logic [7:0]  OFS_STATE    = 8'h18;

	// =========================================================
	// fields
	localparam int unsigned NUM_LR       = 2;
	localparam int unsigned SPE_BIT      = 0;
	localparam int unsigned B3_W         = 6;
	localparam int unsigned B3_STBY_LSB  = 8;
	localparam int unsigned B3_SLP_LSB   = 16;
	localparam int unsigned CFG_W        = 12;
	localparam int unsigned CFG_SP_W     = 5;
	localparam int unsigned CFG_EN       = 8;
	localparam int unsigned CFG_STBY     = 9;
	localparam int unsigned CFG_SLEEP    = 10;
	localparam int unsigned CFG_LP       = 11;
	localparam logic [11:0] CFG_RST      = 12'h000;
	localparam logic [11:0] CFG_WMASK    = 12'hF1F;
	localparam int unsigned ST_ACT_LSB   = 4;
	localparam int unsigned ST_FULL_LSB  = 8;

	// =========================================================
	// set-point encoding, millivolts
	localparam int unsigned MV_W         = 12;
	localparam logic [11:0] B3_BASE_MV   = 12'h708;
	localparam logic [11:0] B3_STEP_MV   = 12'h064;
	localparam logic [11:0] LR_LO_BASE   = 12'h2EE;
	localparam logic [11:0] LR_LO_STEP   = 12'h032;
	localparam logic [11:0] LR_HI_BASE   = 12'h708;
	localparam logic [11:0] LR_HI_STEP   = 12'h064;

	// =========================================================
	// debounce
	localparam int unsigned DB_W             = 16;
	localparam logic [15:0] DEBOUNCE_CYC_DEF = 16'h03E8;

	function automatic logic [11:0] buck3_code_mv(input logic [3:0] c);
		return B3_BASE_MV + B3_STEP_MV * {8'h00, c};
	endfunction

	function automatic logic [11:0] lr_code_mv(input logic [4:0] c);
		if (c[4]) begin
			return LR_HI_BASE + LR_HI_STEP * {8'h00, c[3:0]};
		end
		return LR_LO_BASE + LR_LO_STEP * {8'h00, c[3:0]};
	endfunction

endpackage

// [hdl/rsf_regctl.sv]
// Purpose: regulator set-point and fault control with APB registers
// Assumes: mode, otp and short detect inputs synchronous to i_clk_sys
// Notes:   APB answer in the access phase, no wait states
//
// Notes on behaviour
// - Leaving off mode for run copies the otp buck-three code to all three set points.
// - The buck-three set points ignore APB writes.
// - Buck-three code n gives 1800 mV plus 100 mV per step of its low four bits.
// - Linreg codes below 16 give 750 mV plus 50 mV steps, codes 16 and above give 1800 mV plus 100 mV steps.
// - A linreg that is not enabled has its discharge pulldown on.
// - With the switch bit set a linreg that is on has its pass device driven fully on.
// - A debounced short with protection on clears the enable and flags the fault together.
// - Each fault flag has a mask bit that keeps it off the interrupt.
// - A debounced short always sets the fault flag.
// - Protection enable resets to zero and changes only by software write.
// - With protection off a short never clears the enable.
// - A short must persist through the debounce interval before any action.
// - Linregs one and three are two instances of the same control module.
// - A linreg is on in run when enabled, in standby or sleep only with its mode bit.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module rsf_regctl
	import rsf_pkg::*;
#(
	parameter logic [DB_W-1:0] DEBOUNCE_CYC = DEBOUNCE_CYC_DEF
) (
	input  wire logic                    i_clk_sys,
	input  wire logic                    i_rst,
	input  wire logic                    i_psel,
	input  wire logic                    i_penable,
	input  wire logic                    i_pwrite,
	input  wire logic [ADDR_W-1:0]       i_paddr,
	input  wire logic [DATA_W-1:0]       i_pwdata,
	output wire logic [DATA_W-1:0]       o_prdata,
	output wire logic                    o_pready,
	output wire logic                    o_pslverr,
	input  wire rsf_mode_t               i_pmic_mode,
	input  wire logic [B3_W-1:0]         i_otp_buck3_code,
	input  wire logic [NUM_LR-1:0]       i_otp_linreg13_switch_bit,
	input  wire logic [NUM_LR-1:0]       i_sc_detect,
	output wire logic [B3_W-1:0]         o_buck3_setpoint,
	output wire logic [MV_W-1:0]         o_buck3_mv,
	output wire logic                    o_irq,
	output wire logic [NUM_LR-1:0]       o_lr_on,
	output wire logic [NUM_LR-1:0]       o_lr_low_power,
	output wire logic [NUM_LR-1:0]       o_lr_discharge,
	output wire logic [NUM_LR-1:0]       o_lr_full_on,
	output wire logic [NUM_LR-1:0][MV_W-1:0] o_lr_mv
);

	// =========================================================
	// state
	typedef struct packed {
		rsf_mode_t         prev_mode;
		logic [B3_W-1:0]   b3_run;
		logic [B3_W-1:0]   b3_stby;
		logic [B3_W-1:0]   b3_slp;
		logic [B3_W-1:0]   b3_out;
		logic [MV_W-1:0]   b3_mv;
		logic              spe;
		logic [NUM_LR-1:0] stat;
		logic [NUM_LR-1:0] mask;
		logic              irq;
		logic              pready;
		logic [DATA_W-1:0] prdata;
		logic              pslverr;
	} rsf_top_state_t;

	localparam rsf_top_state_t TOP_RST = '{
		prev_mode: MODE_OFF, b3_run: '0, b3_stby: '0, b3_slp: '0,
		b3_out: '0, b3_mv: B3_BASE_MV, spe: 1'b0, stat: '0, mask: '0,
		irq: 1'b0, pready: 1'b0, prdata: '0, pslverr: 1'b0
	};

	rsf_top_state_t          s_reg;
	rsf_top_state_t          s_next;
	logic                    access;
	logic                    wr;
	logic                    start_load;
	logic [NUM_LR-1:0]       wr_lr;
	logic [NUM_LR-1:0]       w1c;
	logic [B3_W-1:0]         b3_sel;
	logic [NUM_LR-1:0][CFG_W-1:0] cfg_a;
	logic [NUM_LR-1:0]       evt_a;
	logic [NUM_LR-1:0]       act_a;

	// =========================================================
	// address decode
	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		return a == OFS_CTRL || a == OFS_BUCK3 || a == OFS_LR1 ||
			a == OFS_LR3 || a == OFS_INT_STAT || a == OFS_INT_MASK ||
			a == OFS_STATE;
	endfunction

	function automatic logic [DATA_W-1:0] rd_value(
		input logic [ADDR_W-1:0] a,
		input rsf_top_state_t    s
	);
		logic [DATA_W-1:0] d;
		d = '0;
		case (a)
			OFS_CTRL:     d[SPE_BIT] = s.spe;
			OFS_BUCK3:    begin
				d[B3_W-1:0]                     = s.b3_run;
				d[B3_STBY_LSB +: B3_W]          = s.b3_stby;
				d[B3_SLP_LSB +: B3_W]           = s.b3_slp;
			end
			OFS_LR1:      d[CFG_W-1:0] = cfg_a[0];
			OFS_LR3:      d[CFG_W-1:0] = cfg_a[1];
			OFS_INT_STAT: d[NUM_LR-1:0] = s.stat;
			OFS_INT_MASK: d[NUM_LR-1:0] = s.mask;
			OFS_STATE:    begin
				d[NUM_LR-1:0]              = o_lr_on;
				d[ST_ACT_LSB +: NUM_LR]    = act_a;
				d[ST_FULL_LSB +: NUM_LR]   = o_lr_full_on;
			end
			default:      d = '0;
		endcase
		return d;
	endfunction

	// =========================================================
	// next state
	always_comb begin
		s_next           = s_reg;
		s_next.prev_mode = i_pmic_mode;
		access     = i_psel & i_penable & s_reg.pready;
		wr         = access & i_pwrite;
		start_load = s_reg.prev_mode == MODE_OFF &&
			i_pmic_mode == MODE_RUN;
		wr_lr[0]   = wr && i_paddr == OFS_LR1;
		wr_lr[1]   = wr && i_paddr == OFS_LR3;
		w1c        = '0;

		if (start_load) begin
			s_next.b3_run  = i_otp_buck3_code;
			s_next.b3_stby = i_otp_buck3_code;
			s_next.b3_slp  = i_otp_buck3_code;
		end

		unique case (i_pmic_mode)
			MODE_OFF:     b3_sel = s_reg.b3_run;
			MODE_RUN:     b3_sel = s_reg.b3_run;
			MODE_STANDBY: b3_sel = s_reg.b3_stby;
			MODE_SLEEP:   b3_sel = s_reg.b3_slp;
		endcase
		s_next.b3_out = b3_sel;
		s_next.b3_mv  = buck3_code_mv(b3_sel[3:0]);

		// buck-three set points take no write path
		if (wr) begin
			if (i_paddr == OFS_CTRL) begin
				s_next.spe = i_pwdata[SPE_BIT];
			end
			if (i_paddr == OFS_INT_MASK) begin
				s_next.mask = i_pwdata[NUM_LR-1:0];
			end
			if (i_paddr == OFS_INT_STAT) begin
				w1c = i_pwdata[NUM_LR-1:0];
			end
		end

		// set wins over write-one-to-clear
		s_next.stat = (s_reg.stat & ~w1c) | evt_a;
		s_next.irq  = |(s_next.stat & ~s_next.mask);

		s_next.pready  = i_psel & ~i_penable;
		s_next.pslverr = i_psel & ~i_penable & ~addr_mapped(i_paddr);
		s_next.prdata  = '0;
		if (i_psel && !i_penable && !i_pwrite) begin
			s_next.prdata = rd_value(i_paddr, s_reg);
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			s_reg <= TOP_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// =========================================================
	// linear regulators one and three
	rsf_lr_if lr_if [NUM_LR] ();

	genvar g;
	generate
		for (g = 0; g < NUM_LR; g++) begin : g_lr
			assign lr_if[g].wr         = wr_lr[g];
			assign lr_if[g].wdata      = i_pwdata[CFG_W-1:0];
			assign lr_if[g].mode       = i_pmic_mode;
			assign lr_if[g].spe        = s_reg.spe;
			assign lr_if[g].sc_raw     = i_sc_detect[g];
			assign lr_if[g].otp_switch = i_otp_linreg13_switch_bit[g];
			assign cfg_a[g]            = lr_if[g].cfg;
			assign evt_a[g]            = lr_if[g].evt;
			assign act_a[g]            = lr_if[g].active;
			assign o_lr_on[g]          = lr_if[g].on;
			assign o_lr_low_power[g]   = lr_if[g].low_power;
			assign o_lr_discharge[g]   = lr_if[g].discharge;
			assign o_lr_full_on[g]     = lr_if[g].full_on;
			assign o_lr_mv[g]          = lr_if[g].mv;

			rsf_linreg #(
				.DEBOUNCE_CYC (DEBOUNCE_CYC)
			) u_lr (
				.i_clk_sys (i_clk_sys),
				.i_rst     (i_rst),
				.lr        (lr_if[g])
			);
		end
	endgenerate

	// =========================================================
	// outputs
	assign o_prdata         = s_reg.prdata;
	assign o_pready         = s_reg.pready;
	assign o_pslverr        = s_reg.pslverr;
	assign o_buck3_setpoint = s_reg.b3_out;
	assign o_buck3_mv       = s_reg.b3_mv;
	assign o_irq            = s_reg.irq;

	// =========================================================
	// checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	buck3_load_a: assert property (
		s_reg.prev_mode == MODE_OFF && i_pmic_mode == MODE_RUN
		|=> s_reg.b3_run == $past(i_otp_buck3_code)
		&& s_reg.b3_stby == $past(i_otp_buck3_code)
		&& s_reg.b3_slp == $past(i_otp_buck3_code)
	) else $error("buck three set points not loaded at start");

	buck3_readonly_a: assert property (
		wr && i_paddr == OFS_BUCK3 && !start_load
		|=> $stable(s_reg.b3_run) && $stable(s_reg.b3_stby)
		&& $stable(s_reg.b3_slp)
	) else $error("buck three set point changed by write");

	buck3_volt_a: assert property (
		i_pmic_mode == MODE_RUN ##1 i_pmic_mode == MODE_RUN
		|=> o_buck3_mv == B3_BASE_MV + B3_STEP_MV *
		{8'h00, $past(s_reg.b3_run[3:0])}
	) else $error("buck three voltage encoding wrong");

	protect_hold_a: assert property (
		!(wr && i_paddr == OFS_CTRL) |=> $stable(s_reg.spe)
	) else $error("protection enable changed without write");

	irq_mask_a: assert property (
		(s_reg.stat & ~s_reg.mask) == '0 |-> !o_irq
	) else $error("masked fault raised the interrupt");

	fault_flag_a: assert property (
		|evt_a |=> (s_reg.stat & $past(evt_a)) == $past(evt_a)
	) else $error("fault flag not set on short");

	fault_same_time_a: assert property (
		evt_a[0] && s_reg.spe |=> s_reg.stat[0] && !cfg_a[0][CFG_EN]
	) else $error("enable clear and flag not together");

	apb_answer_a: assert property (
		i_psel && !i_penable |=> o_pready
	) else $error("no answer in access phase");

	lr3_fault_clear_a: assert property (
		evt_a[1] && s_reg.spe |=> s_reg.stat[1] && !cfg_a[1][CFG_EN]
	) else $error("enable clear and flag not together on lr3");

	irq_raise_a: assert property (
		(s_reg.stat & ~s_reg.mask) != '0 |-> o_irq
	) else $error("unmasked fault did not raise the interrupt");

	ready_one_a: assert property (
		o_pready |=> !o_pready
	) else $error("ready held longer than one cycle");

	unmapped_err_a: assert property (
		i_psel && !i_penable && !addr_mapped(i_paddr)
		|=> o_pslverr && o_prdata == '0
	) else $error("unmapped address not refused");

	buck3_stby_out_a: assert property (
		i_pmic_mode == MODE_STANDBY
		|=> o_buck3_setpoint == $past(s_reg.b3_stby)
	) else $error("standby set point not selected");

	buck3_sleep_out_a: assert property (
		i_pmic_mode == MODE_SLEEP
		|=> o_buck3_setpoint == $past(s_reg.b3_slp)
	) else $error("sleep set point not selected");

	stat_clear_a: assert property (
		wr && i_paddr == OFS_INT_STAT && evt_a == '0
		|=> (s_reg.stat & $past(i_pwdata[NUM_LR-1:0])) == '0
	) else $error("fault flag not cleared by write of one");

	discharge_pair_a: assert property (
		o_lr_discharge == ~o_lr_on
	) else $error("discharge not the inverse of on");

endmodule

// [tb/testbench.sv]
// Purpose: self-checking bench for the regulator set-point and fault block
// Assumes: APB with no wait states, short debounce shortened to 4 cycles
// Notes:   every scenario drives the ports and judges outputs itself
`timescale 1ns/1ps
module testbench;
	import rsf_pkg::*;

	// ==========================================================
	// signals
	localparam logic [15:0] DB = 16'h0004;
	logic                    clk_sys;
	logic                    rst;
	logic                    psel;
	logic                    penable;
	logic                    pwrite;
	logic [ADDR_W-1:0]       paddr;
	logic [DATA_W-1:0]       pwdata;
	logic [DATA_W-1:0]       prdata;
	logic                    pready;
	logic                    pslverr;
	rsf_mode_t               pmic_mode;
	logic [B3_W-1:0]         otp_code;
	logic [NUM_LR-1:0]       otp_switch;
	logic [NUM_LR-1:0]       sc_detect;
	logic [B3_W-1:0]         buck3_sp;
	logic [MV_W-1:0]         buck3_mv;
	logic                    irq;
	logic [NUM_LR-1:0]       lr_on;
	logic [NUM_LR-1:0]       lr_lp;
	logic [NUM_LR-1:0]       lr_dis;
	logic [NUM_LR-1:0]       lr_full;
	logic [NUM_LR-1:0][MV_W-1:0] lr_mv;
	logic [31:0]             rdata;
	logic                    rerr;
	int                      bad_count;
	int                      n_tests;

	rsf_regctl #(.DEBOUNCE_CYC(DB)) i_dut (
		.i_clk_sys                 (clk_sys),
		.i_rst                     (rst),
		.i_psel                    (psel),
		.i_penable                 (penable),
		.i_pwrite                  (pwrite),
		.i_paddr                   (paddr),
		.i_pwdata                  (pwdata),
		.o_prdata                  (prdata),
		.o_pready                  (pready),
		.o_pslverr                 (pslverr),
		.i_pmic_mode               (pmic_mode),
		.i_otp_buck3_code          (otp_code),
		.i_otp_linreg13_switch_bit (otp_switch),
		.i_sc_detect               (sc_detect),
		.o_buck3_setpoint          (buck3_sp),
		.o_buck3_mv                (buck3_mv),
		.o_irq                     (irq),
		.o_lr_on                   (lr_on),
		.o_lr_low_power            (lr_lp),
		.o_lr_discharge            (lr_dis),
		.o_lr_full_on              (lr_full),
		.o_lr_mv                   (lr_mv)
	);

	// ==========================================================
	// helpers
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// setup on one edge, access until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 16) begin
			n++;
			@(posedge clk_sys);
		end
		if (n == 16) begin
			bad_count++;
			$display("wrong value pready expected 1 seen %b", pready);
		end
		rdata = prdata;
		rerr  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a,
			input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rdata);
	endtask

	task automatic pulse_sc(input int i, input int n);
		@(posedge clk_sys);
		sc_detect[i] <= 1'b1;
		repeat (n) @(posedge clk_sys);
		sc_detect[i] <= 1'b0;
		cyc(4);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		chk("lr discharge", 32'h3, {30'h0, lr_dis});
		chk("lr1 mv", 32'd750, {20'h0, lr_mv[0]});
		chk("buck3 mv", 32'd1800, {20'h0, buck3_mv});
		rd_chk("ctrl", OFS_CTRL, 32'h0000_0000);
		rd_chk("buck3", OFS_BUCK3, 32'h0000_0000);
		rd_chk("lr3 cfg", OFS_LR3, 32'h0000_0000);
		rd_chk("int mask", OFS_INT_MASK, 32'h0000_0000);
		apb(1'b0, 8'h1C, 32'h0000_0000);
		chk("unmapped err", 32'h1, {31'h0, rerr});
		chk("unmapped data", 32'h0, rdata);
		apb(1'b1, OFS_LR1, 32'hFFFF_FFFF);
		rd_chk("lr1 cfg mask", OFS_LR1, 32'h0000_0F1F);
		apb(1'b1, OFS_LR1, 32'h0000_0000);
		$display("test reset done");
	endtask

	task automatic t_buck3();
		logic [5:0]  c;
		logic [31:0] e;
		for (int k = 0; k < 3; k++) begin
			c = (k == 0) ? 6'h00 : ((k == 1) ? 6'h25 : 6'h3F);
			e = {10'h0, c, 2'h0, c, 2'h0, c};
			@(posedge clk_sys);
			pmic_mode <= MODE_OFF;
			otp_code  <= c;
			cyc(3);
			@(posedge clk_sys);
			pmic_mode <= MODE_RUN;
			cyc(4);
			chk("buck3 sp", {26'h0, c}, {26'h0, buck3_sp});
			chk("buck3 mv", 1800 + 100 * c[3:0], {20'h0, buck3_mv});
			rd_chk("buck3 regs", OFS_BUCK3, e);
			apb(1'b1, OFS_BUCK3, ~e);
			rd_chk("buck3 ro", OFS_BUCK3, e);
		end
		$display("test buck3 done");
	endtask

	task automatic t_lr_code();
		logic [4:0]  c;
		logic [31:0] e;
		for (int k = 0; k < 4; k++) begin
			c = (k < 2) ? 5'(k * 15) : 5'(16 + (k - 2) * 15);
			e = c[4] ? 1800 + 100 * c[3:0] : 750 + 50 * c[3:0];
			apb(1'b1, OFS_LR1, {27'h0, c});
			apb(1'b1, OFS_LR3, {27'h0, c});
			cyc(3);
			chk("lr1 mv", e, {20'h0, lr_mv[0]});
			chk("lr3 mv", e, {20'h0, lr_mv[1]});
		end
		$display("test linreg code done");
	endtask

	// entry: mode[7:6] cfg[11:8] at [5:2] expected on [1] low power [0]
	localparam logic [7:0] MT [10] = '{8'h46, 8'h40, 8'h84, 8'h8E, 8'hAF,
		8'hCC, 8'hD6, 8'hF7, 8'h66, 8'h04};

	task automatic t_modes();
		logic o;
		logic l;
		otp_switch <= 2'b10;
		for (int k = 0; k < 10; k++) begin
			o = MT[k][1];
			l = MT[k][0];
			@(posedge clk_sys);
			pmic_mode <= rsf_mode_t'(MT[k][7:6]);
			apb(1'b1, OFS_LR1, {20'h0, MT[k][5:2], 8'h00});
			apb(1'b1, OFS_LR3, {20'h0, MT[k][5:2], 8'h00});
			cyc(3);
			chk("lr on", {30'h0, o, o}, {30'h0, lr_on});
			chk("lr low power", {30'h0, l, l}, {30'h0, lr_lp});
			chk("lr discharge", {30'h0, ~o, ~o}, {30'h0, lr_dis});
			chk("lr full on", {30'h0, o, 1'b0}, {30'h0, lr_full});
		end
		$display("test modes done");
	endtask

	task automatic t_short();
		@(posedge clk_sys);
		pmic_mode <= MODE_RUN;
		apb(1'b1, OFS_LR1, 32'h0000_0100);
		apb(1'b1, OFS_LR3, 32'h0000_0100);
		pulse_sc(0, 3);
		rd_chk("stat short pulse", OFS_INT_STAT, 32'h0);
		chk("irq short pulse", 32'h0, {31'h0, irq});
		pulse_sc(0, 10);
		rd_chk("stat spe off", OFS_INT_STAT, 32'h1);
		chk("irq spe off", 32'h1, {31'h0, irq});
		chk("lr1 stays on", 32'h3, {30'h0, lr_on});
		rd_chk("lr1 en kept", OFS_LR1, 32'h0000_0100);
		apb(1'b1, OFS_INT_MASK, 32'h0000_0001);
		cyc(2);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, OFS_INT_STAT, 32'h0000_0001);
		rd_chk("stat cleared", OFS_INT_STAT, 32'h0);
		apb(1'b1, OFS_INT_MASK, 32'h0000_0000);
		apb(1'b1, OFS_CTRL, 32'hFFFF_FFFF);
		rd_chk("ctrl", OFS_CTRL, 32'h0000_0001);
		pulse_sc(1, 10);
		rd_chk("stat spe on", OFS_INT_STAT, 32'h2);
		chk("irq spe on", 32'h1, {31'h0, irq});
		rd_chk("lr3 en cleared", OFS_LR3, 32'h0000_0000);
		chk("lr3 off", 32'h1, {30'h0, lr_on});
		chk("lr3 discharge", 32'h2, {30'h0, lr_dis});
		rd_chk("state", OFS_STATE, 32'h0000_0001);
		apb(1'b1, OFS_INT_STAT, 32'h0000_0003);
		cyc(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		cyc(1);
		rd_chk("ctrl after reset", OFS_CTRL, 32'h0000_0000);
		chk("discharge after reset", 32'h3, {30'h0, lr_dis});
		$display("test short done");
	endtask

	// ==========================================================
	// clock, watchdog, main sequence
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	initial begin
		#200000;
		bad_count++;
		$display("wrong value watchdog expected done seen hang");
		stop_test();
	end

	initial begin
		bad_count  = 0;
		n_tests    = 0;
		rst        = 1'b1;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 8'h00;
		pwdata     = 32'h0000_0000;
		pmic_mode  = MODE_OFF;
		otp_code   = 6'h00;
		otp_switch = 2'b00;
		sc_detect  = 2'b00;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		cyc(1);
		t_reset();
		t_buck3();
		t_lr_code();
		t_modes();
		t_short();
		stop_test();
	end
endmodule
